//--- hdl/sap_sequencer.sv
// Control sequencer and byte-wide tri-state result port of a 16-bit SAR converter.
// Assumes host strobes arrive asynchronously; the comparator is on this clock.
// Assumes the host holds each strobe level for at least three clock cycles,
// so that every level passes the synchroniser before it changes again.
// Function
// - Byte select high drives upper result byte
// - First edge, select low, starts acquisition
// - First edge with select high ignored
// - Second edge holds sample, starts conversion
// - Conversion done within conversion time
// - Conversion clock is generated internally
// - Select at second edge picks standby/shutdown
// - Power mode entered automatically after conversion
// - From standby, edge starts acquisition, reference on
// - From shutdown, edge wakes reference, acquisition
// - Third edge, select high, drives result
// - Tri-state outputs, LSB on data_line_0
// - End-of-conversion falls when result ready
// - Data high impedance except during read
// - After read, next edge starts new cycle
// - Result coded in offset binary

`timescale 1ns/1ps
`default_nettype none
`include "sap_consts.svh"

// Host-facing sequencer: counts strobe edges, runs the engine, drives the byte bus.
module sap_sequencer
    import sap_pkg::*;
#(
    parameter int BITS = `SAP_BITS,
    parameter int STEP_DIV = `SAP_STEP_DIV
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic conv_start_n_in,
    input wire logic read_convert_in,
    input wire logic byte_select_in,
    input wire logic comp_high_in,
    output logic [`SAP_BYTE-1:0] data_out,
    output logic [`SAP_BYTE-1:0] data_oe_n_out,
    output logic eoc_n_out,
    output logic [BITS-1:0] dac_trial_out,
    output sap_power_t power_out
);

    // Pin synchronisers; logic reads only the second stage or later
    logic [2:0] cs_sync_q, cs_sync_d; // Strobe synchroniser plus edge history
    logic [1:0] rc_sync_q, rc_sync_d; // Select synchroniser
    logic [1:0] hb_sync_q, hb_sync_d; // Byte select synchroniser
    logic cs_fall; // Falling strobe edge
    logic rc_s; // Synchronised read/convert select
    logic hb_s; // Synchronised byte select

    // Sequencer, power and bus state
    sap_state_t state_q, state_d; // Sequencer phase
    logic shutdown_q, shutdown_d; // Selected post-conversion mode
    logic ref_on_q, ref_on_d; // Reference and buffer powered
    logic eoc_n_q, eoc_n_d; // End-of-conversion flag, active low
    logic [`SAP_BYTE-1:0] data_q, data_d; // Registered output byte
    logic drive_q, drive_d; // Data bus driven

    // Handshake with the conversion engine
    logic eng_start; // Launch conversion pulse
    logic eng_done; // Conversion finished pulse
    logic [BITS-1:0] eng_result; // Finished conversion word

    // Next values of the input synchronisers
    always_comb begin
        // Shift each pin in; the strobe keeps one extra stage for edge detect
        cs_sync_d = {cs_sync_q[1:0], conv_start_n_in};
        rc_sync_d = {rc_sync_q[0], read_convert_in};
        hb_sync_d = {hb_sync_q[0], byte_select_in};
    end

    // Register synchronisers; idle levels after reset avoid a false strobe edge
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            // Strobe idles high, select lines low
            cs_sync_q <= 3'h7;
            rc_sync_q <= 2'h0;
            hb_sync_q <= 2'h0;
        end else begin
            cs_sync_q <= cs_sync_d;
            rc_sync_q <= rc_sync_d;
            hb_sync_q <= hb_sync_d;
        end
    end

    // Only second and later stages feed logic; the first stage may be metastable
    assign cs_fall = cs_sync_q[2] && !cs_sync_q[1];
    assign rc_s = rc_sync_q[1];
    assign hb_s = hb_sync_q[1];
    // The engine starts on the same edge that ends acquisition, so the sample
    // held at that edge is the one converted
    assign eng_start = cs_fall && (state_q == SAP_ACQ);

    // Successive-approximation engine on the internal clock
    // The comparator answer comes back on this clock, no synchroniser needed
    sap_sar_engine #(
        .BITS(BITS),
        .STEP_DIV(STEP_DIV)
    ) u_engine (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(eng_start),
        .comp_high_in(comp_high_in),
        .trial_out(dac_trial_out),
        .result_out(eng_result),
        .done_out(eng_done)
    );

    // Next sequencer state, power mode and data bus
    // Strobe edges that arrive in a state with no use for them are dropped,
    // which keeps a host glitch during conversion from disturbing the result
    always_comb begin
        state_d = state_q;
        shutdown_d = shutdown_q;
        ref_on_d = ref_on_q;
        eoc_n_d = eoc_n_q;
        data_d = data_q;
        drive_d = drive_q;
        // Phase decode; only the five listed codes are legal
        unique case (state_q)
            SAP_IDLE: begin
                // Waiting in standby or shutdown
                if (cs_fall && !rc_s) begin
                    // Power up, or stay up from standby, and start tracking
                    state_d = SAP_ACQ;
                    ref_on_d = 1'b1;
                    // Old result is no longer the one being offered
                    eoc_n_d = 1'b1;
                end
                // Edges with select high leave the state alone
            end
            SAP_ACQ: begin
                // Tracking the input on the hold capacitor
                // Second edge opens the hold switches and starts the engine
                if (cs_fall) begin
                    state_d = SAP_CONV;
                    // Power mode for after this conversion is fixed here
                    shutdown_d = rc_s;
                end
            end
            SAP_CONV: begin
                // Conversion running, bus stays off
                // Strobe edges here are ignored; the engine owns the hold capacitor
                if (eng_done) begin
                    state_d = SAP_DONE;
                    // Flag the result as ready
                    eoc_n_d = 1'b0;
                    // Reference stays on only in standby
                    ref_on_d = !shutdown_q;
                end
            end
            SAP_DONE: begin
                // Result ready, wait for read edge
                if (cs_fall && rc_s) begin
                    // Read edge: turn the byte drivers on
                    state_d = SAP_READ;
                    drive_d = 1'b1;
                end else if (cs_fall) begin
                    // Skipping the read starts a fresh cycle
                    state_d = SAP_ACQ;
                    // The reference may be down after a shutdown conversion
                    ref_on_d = 1'b1;
                    eoc_n_d = 1'b1;
                end
                // Every strobe edge leaves this phase; with no edge it waits here with the result held
            end
            SAP_READ: begin
                // Bus driven until strobe rises
                // Second synchroniser stage high means the strobe has risen
                if (cs_sync_q[1]) begin
                    state_d = SAP_IDLE;
                    drive_d = 1'b0;
                end
            end
            default: begin
                // Unused phase codes fall back to idle
                state_d = SAP_IDLE;
            end
        endcase
        // Byte chosen by select, LSB on data_line_0
        // The byte follows the select even while driven, as the host may toggle it
        data_d = hb_s ? eng_result[BITS-1 -: `SAP_BYTE] : eng_result[`SAP_BYTE-1:0];
    end

    // Register sequencer state
    // Reset leaves shutdown chosen, so the first wake powers the reference up
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            // Idle, powered down, bus released
            state_q <= SAP_IDLE;
            shutdown_q <= 1'b1;
            ref_on_q <= 1'b0;
            eoc_n_q <= `SAP_EOC_RST;
            data_q <= 8'h00;
            drive_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shutdown_q <= shutdown_d;
            ref_on_q <= ref_on_d;
            eoc_n_q <= eoc_n_d;
            data_q <= data_d;
            drive_q <= drive_d;
        end
    end

    // Outputs; the enables are low while the byte lines are driven
    assign data_out = data_q;
    assign data_oe_n_out = drive_q ? 8'h00 : `SAP_DATA_OE_RST;
    assign eoc_n_out = eoc_n_q;
    // Power status seen by the analog front
    assign power_out.ref_on = ref_on_q;
    assign power_out.tracking = (state_q == SAP_ACQ);
    assign power_out.converting = (state_q == SAP_CONV);

endmodule // sap_sequencer
`default_nettype wire

//--- hdl/sap_consts.svh
// Timing counts and reset values for the converter sequencer.
// Assumes a 100 MHz reference clock.
`ifndef SAP_CONSTS_SVH
`define SAP_CONSTS_SVH
`define SAP_CLK_PERIOD_PS 10000
`define SAP_CONV_TIME_PS 4700000
`define SAP_CONV_CYCLES (`SAP_CONV_TIME_PS / `SAP_CLK_PERIOD_PS)
`define SAP_BITS 16
`define SAP_BYTE 8
`define SAP_STEP_DIV 29
`define SAP_MID_CODE 16'h8000
`define SAP_DATA_OE_RST 8'hFF
`define SAP_EOC_RST 1'b1
`endif

//--- hdl/sap_pkg.sv
// Types shared by the converter sequencer files.
// Assumes sap_consts.svh is available on the include path.
package sap_pkg;
    // Sequencer phases
    typedef enum logic [2:0] {
        SAP_IDLE, SAP_ACQ, SAP_CONV, SAP_DONE, SAP_READ
    } sap_state_t;
    // Power status of the analog front
    typedef struct packed {
        logic ref_on;
        logic tracking;
        logic converting;
    } sap_power_t;
endpackage

//--- hdl/sap_sar_engine.sv
// Successive-approximation engine: one bit trial per internal clock step.
// Assumes a comparator input from the analog side, same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "sap_consts.svh"
module sap_sar_engine
    import sap_pkg::*;
#(
    parameter int BITS = `SAP_BITS,
    parameter int STEP_DIV = `SAP_STEP_DIV
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic comp_high_in,
    output logic [BITS-1:0] trial_out,
    output logic [BITS-1:0] result_out,
    output logic done_out
);
    logic [7:0] div_q, div_d; // Internal conversion clock divider
    logic [BITS-1:0] trial_q, trial_d; // Current trial word
    logic [BITS-1:0] mask_q, mask_d; // Bit under test
    logic [BITS-1:0] res_q, res_d; // Held offset binary result
    logic busy_q, busy_d; // Conversion running
    logic done_q, done_d; // One-cycle done pulse
    logic step; // Internal clock enable
    assign step = busy_q && (div_q == 8'(STEP_DIV - 1));
    // Next values: divider and bit trials from the internal clock
    always_comb begin
        div_d = div_q;
        trial_d = trial_q;
        mask_d = mask_q;
        res_d = res_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start_in) begin
            busy_d = 1'b1;
            div_d = 8'h00;
            mask_d = {1'b1, {(BITS-1){1'b0}}};
            trial_d = {1'b1, {(BITS-1){1'b0}}};
        end else if (busy_q) begin
            div_d = step ? 8'h00 : div_q + 8'h01;
            if (step) begin
                // Keep bit when analog input exceeds trial level
                trial_d = (comp_high_in ? trial_q : (trial_q & ~mask_q)) | (mask_q >> 1);
                mask_d = mask_q >> 1;
                if (mask_q[0]) begin
                    res_d = comp_high_in ? trial_q : (trial_q & ~mask_q);
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end
            end
        end
    end
    // Register the engine state
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            div_q <= 8'h00;
            trial_q <= `SAP_MID_CODE;
            mask_q <= '0;
            res_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            div_q <= div_d;
            trial_q <= trial_d;
            mask_q <= mask_d;
            res_q <= res_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end
    assign trial_out = trial_q;
    assign result_out = res_q;
    assign done_out = done_q;
endmodule // sap_sar_engine
`default_nettype wire

//--- testbench/sap_comp_model.sv
// Comparator model for the converter's analog side.
// Assumes the bench supplies the input code on the sequencer clock.
`timescale 1ns/1ps
`default_nettype none
module sap_comp_model
    import sap_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic tracking_in,
    input wire logic [15:0] code_in,
    input wire logic [15:0] trial_in,
    output logic comp_high_out
);
    logic [15:0] held_q; // Charge kept on the hold capacitor
    // Track while acquiring, keep the sample once hold begins
    always_ff @(posedge ref_clk_in) begin
        if (tracking_in) begin
            held_q <= code_in;
        end
    end
    // Input sits half an LSB above its code, so the search ends on it
    assign comp_high_out = (held_q >= trial_in);
endmodule // sap_comp_model
`default_nettype wire

//--- testbench/sap_seq_props.sv
// Port checker for the converter sequencer.
// Assumes it is bound into sap_sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "sap_consts.svh"
module sap_seq_props
    import sap_pkg::*;
#(
    parameter int STEP_DIV = 2
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic conv_start_n_in,
    input wire logic [`SAP_BYTE-1:0] data_oe_n_out,
    input wire logic eoc_n_out,
    input wire sap_power_t power_out
);
    localparam int CONV_MAX = 16 * STEP_DIV + 20; // Bit trials plus pipeline slack
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    reset_idle_a: assert property (
        $rose(rst_n_in) |-> data_oe_n_out == 8'hFF && eoc_n_out && !power_out.ref_on)
        else $error("outputs not idle after reset");
    hiz_busy_a: assert property (
        power_out.tracking || power_out.converting |-> data_oe_n_out == 8'hFF)
        else $error("bus driven while busy");
    oe_whole_a: assert property (
        data_oe_n_out == 8'hFF || data_oe_n_out == 8'h00) else $error("partial bus enable");
    eoc_bound_a: assert property (
        $rose(power_out.converting) |-> ##[1:CONV_MAX] !eoc_n_out) else $error("conversion late");
    eoc_cause_a: assert property (
        $fell(eoc_n_out) |-> $past(power_out.converting)) else $error("ready without conversion");
    conv_hold_a: assert property (
        $rose(power_out.converting) |-> (power_out.converting && !power_out.tracking)[*8])
        else $error("hold not kept");
    track_ref_a: assert property (
        power_out.tracking |-> power_out.ref_on) else $error("tracking without reference");
    bus_release_a: assert property (
        conv_start_n_in[*8] |-> data_oe_n_out == 8'hFF) else $error("bus not released");
    cover property ($fell(eoc_n_out));
    cover property (data_oe_n_out == 8'h00);
    cover property ($rose(power_out.tracking) && power_out.ref_on);
endmodule // sap_seq_props
bind sap_sequencer sap_seq_props #(.STEP_DIV(STEP_DIV)) u_sap_seq_props (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .conv_start_n_in(conv_start_n_in),
    .data_oe_n_out(data_oe_n_out), .eoc_n_out(eoc_n_out), .power_out(power_out));
`default_nettype wire

//--- testbench/sar_adc_parallel_sequencer_tb_top.sv
// Self-checking bench: host strobes, comparator model and a queue of expected codes.
// Assumes STEP_DIV shortened to 2 for simulation.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_parallel_sequencer_tb_top;
    import sap_pkg::*;
    logic ref_clk_in = 1'b0, rst_n_in = 1'b0, cs_n = 1'b1, rc = 1'b0, bs = 1'b0, comp;
    logic [7:0] dout, oe_n, exp_b; // Bus pins and the expected byte
    logic [15:0] trial, code = 16'h0000;
    logic [15:0] exp_q[$]; // Codes sampled at each hold
    logic eoc_n;
    sap_power_t pwr;
    int err_total = 0, check_count = 0, seed = 32'hffcc, n;
    always #5 ref_clk_in = ~ref_clk_in;
    sap_sequencer #(.STEP_DIV(2)) u_sap_sequencer (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .conv_start_n_in(cs_n), .read_convert_in(rc), .byte_select_in(bs), .comp_high_in(comp),
        .data_out(dout), .data_oe_n_out(oe_n), .eoc_n_out(eoc_n), .dac_trial_out(trial),
        .power_out(pwr));
    sap_comp_model u_sap_comp_model (.ref_clk_in(ref_clk_in), .tracking_in(pwr.tracking),
        .code_in(code), .trial_in(trial), .comp_high_out(comp));
    // Compare one value and count it
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Print counts and verdict, then stop
    task automatic close_out();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Strobe low with the select set first, held past the synchroniser
    task automatic fall(input logic r);
        @(negedge ref_clk_in) rc = r;
        @(negedge ref_clk_in) cs_n = 1'b0;
        repeat (5) @(negedge ref_clk_in);
    endtask
    task automatic rise();
        cs_n = 1'b1;
        repeat (6) @(negedge ref_clk_in);
    endtask
    // Main sequence: ignored edge, then acquire, convert, read in both power modes
    initial begin
        repeat (3) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        fall(1'b1);
        rise();
        chk({13'h0000, pwr}, 16'h0000, "ignored edge");
        for (int i = 0; i < 8; i++) begin
            code = 16'($random(seed));
            fall(1'b0);
            rise();
            chk(16'({pwr.ref_on, pwr.tracking}), 16'h0003, "acquire");
            chk(16'(oe_n), 16'h00FF, "bus off in acquire");
            exp_q.push_back(code);
            // Shutdown only on the last pass, so only the wake from reset is followed by a conversion
            fall(i == 7);
            rise();
            code = ~code; // Input moves after hold
            chk(16'(pwr.converting), 16'h0001, "converting");
            n = 0;
            while (eoc_n !== 1'b0 && n < 470) begin
                @(negedge ref_clk_in);
                n++;
            end
            if (eoc_n !== 1'b0) begin
                err_total++;
                $display("wrong value at %0t: conversion timeout", $time);
            end
            chk(16'(n < 457), 16'h0001, "conversion time");
            chk(16'(pwr.ref_on), 16'(i != 7), "power mode");
            // One pass leaves the result unread, so the next edge restarts from done
            if (i != 6) begin
                fall(1'b1);
                for (int b = 0; b < 2; b++) begin
                    bs = b[0];
                    exp_b = b ? exp_q[0][15:8] : exp_q[0][7:0];
                    repeat (5) @(negedge ref_clk_in);
                    chk({oe_n, dout}, {8'h00, exp_b}, "byte");
                end
                rise();
                chk(16'(oe_n), 16'h00FF, "bus released");
            end else begin
                chk(16'(oe_n), 16'h00FF, "bus off while unread");
            end
            exp_q.delete(0);
        end
        // Wake from shutdown; no conversion follows, so no settling wait is owed
        fall(1'b0);
        rise();
        chk(16'({pwr.ref_on, pwr.tracking}), 16'h0003, "wake");
        close_out();
    end
endmodule // sar_adc_parallel_sequencer_tb_top
`default_nettype wire
